/* File: core/vifs_decode.sv */
`timescale 1ns/100ps
// Unpacks a checked packet payload into the three status bytes
module vifs_decode (
   input wire logic [7:0] pb1, // Payload byte 1
   input wire logic [7:0] pb2, // Payload byte 2
   input wire logic [7:0] pb3, // Payload byte 3
   output logic [7:0] fmt_d, // Format/bar/scan byte
   output logic [7:0] col_d, // Colour/aspect byte
   output logic [7:0] scl_d // Scaling byte
);
   // Reserved bits are forced to zero so they always read as zero
   assign fmt_d = {1'b0, pb1[6:5], pb1[4], pb1[3:2], pb1[1:0]};
   assign col_d = {pb2[7:6], pb2[5:4], pb2[3:0]};
   assign scl_d = {6'h00, pb3[1:0]};
endmodule

/* File: core/vifs_pkg.sv */
package vifs_pkg;
   // Register offsets (printed offsets are not word multiples: byte address = 4 * index)
   localparam logic [7:0] VIFS_IDX_FMT = 8'h81;
   localparam logic [7:0] VIFS_IDX_COL = 8'h82;
   localparam logic [7:0] VIFS_IDX_SCL = 8'h83;
   localparam int VIFS_ADR_W = 10;
   // Field positions in the format/bar/scan register
   localparam int VIFS_ENC_LSB = 5;
   localparam int VIFS_AFP_BIT = 4;
   localparam int VIFS_BAR_LSB = 2;
   localparam int VIFS_SCAN_LSB = 0;
   // Field positions in the colour/aspect register
   localparam int VIFS_COLR_LSB = 6;
   localparam int VIFS_PAR_LSB = 4;
   localparam int VIFS_AFAR_LSB = 0;
   // Field positions in the scaling register
   localparam int VIFS_NUS_LSB = 0;
   // Packet payload byte layout: byte1 = {0,Y,A,B,S}, byte2 = {C,M,R}, byte3 = {..,SC}
   localparam int VIFS_PKT_BYTES = 3;
   // Reset values
   localparam logic [7:0] VIFS_RST_FMT = 8'h00;
   localparam logic [7:0] VIFS_RST_COL = 8'h00;
   localparam logic [7:0] VIFS_RST_SCL = 8'h00;
endpackage

/* File: core/vifs_top.sv */
`timescale 1ns/100ps
// Overview of operation
// - Bits 6:5 report pixel encoding: RGB, YCbCr 4:2:2, YCbCr 4:4:4.
// - Bit 4 is format-present flag; zero means no active format data.
// - Format-present flag is one when packet marks aspect data valid.
// - Bits 3:2 report bar descriptor: none, horizontal, vertical, both.
// - Bits 1:0 report scan descriptor: none, overscanned, underscanned.
// - Register video_colour_and_aspect_info bits 7:6 hold colorimetry code.
// - Bits 5:4 picture aspect, bits 3:0 active format aspect.
// - Register video_scaling_info bits 1:0 report non-uniform scaling.
module vifs_top (
   input wire logic SYS_CLK, // 200 MHz clock
   input wire logic NRST, // Synchronous reset, active low
   input wire logic [7:0] PKT_BYTE1, // Received payload byte 1
   input wire logic [7:0] PKT_BYTE2, // Received payload byte 2
   input wire logic [7:0] PKT_BYTE3, // Received payload byte 3
   input wire logic PKT_VALID, // One-cycle pulse: checked packet ready
   input wire logic WB_CYC_I, // Wishbone cycle
   input wire logic WB_STB_I, // Wishbone strobe
   input wire logic WB_WE_I, // Wishbone write enable
   input wire logic [3:0] WB_SEL_I, // Wishbone byte selects
   input wire logic [9:0] WB_ADR_I, // Wishbone byte address
   input wire logic [31:0] WB_DAT_I, // Wishbone write data, ignored
   output logic [31:0] WB_DAT_O, // Wishbone read data
   output logic WB_ACK_O // Wishbone acknowledge
);
   logic [7:0] fmt_q;
   logic [7:0] col_q;
   logic [7:0] scl_q;
   logic [7:0] fmt_d;
   logic [7:0] col_d;
   logic [7:0] scl_d;
   logic ack_q;
   logic [31:0] dat_q;
   logic req;

   // Field extraction kept apart so the packet layout lives in one place
   vifs_decode u_dec (
      .pb1(PKT_BYTE1),
      .pb2(PKT_BYTE2),
      .pb3(PKT_BYTE3),
      .fmt_d(fmt_d),
      .col_d(col_d),
      .scl_d(scl_d)
   );

   // Selects the read value for a byte address; unaligned or unmapped reads return zero
   function automatic logic [7:0] rd_sel(input logic [9:0] adr, input logic [7:0] f,
                                         input logic [7:0] c, input logic [7:0] s);
      logic [7:0] r;
      r = 8'h00;
      if (adr[1:0] == 2'h0) begin
         if (adr[9:2] == vifs_pkg::VIFS_IDX_FMT) r = f;
         else if (adr[9:2] == vifs_pkg::VIFS_IDX_COL) r = c;
         else if (adr[9:2] == vifs_pkg::VIFS_IDX_SCL) r = s;
      end
      return r;
   endfunction

   // Status capture: every field loads in the same cycle, so software never sees a mix
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         fmt_q <= vifs_pkg::VIFS_RST_FMT;
         col_q <= vifs_pkg::VIFS_RST_COL;
         scl_q <= vifs_pkg::VIFS_RST_SCL;
      end else if (PKT_VALID) begin
         fmt_q <= fmt_d;
         col_q <= col_d;
         scl_q <= scl_d;
      end
   end

   assign req = WB_CYC_I && WB_STB_I && !ack_q;

   // Bus slave: one wait state, ack for one cycle; writes are acknowledged but dropped
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req;
         if (req && !WB_WE_I) begin
            dat_q <= {24'h00_0000, rd_sel(WB_ADR_I, fmt_q, col_q, scl_q)};
         end
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = dat_q;

   // Checks on the status fields and bus answer
   a_fmt_load: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      PKT_VALID |=> fmt_q == $past(fmt_d)) else $error("Format byte not loaded");
   a_afp_flag: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      PKT_VALID && PKT_BYTE1[4] |=> fmt_q[vifs_pkg::VIFS_AFP_BIT])
      else $error("Format-present flag not set");
   a_afp_clear: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      PKT_VALID && !PKT_BYTE1[4] |=> !fmt_q[vifs_pkg::VIFS_AFP_BIT])
      else $error("Format-present flag set without data");
   a_bar_field: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      PKT_VALID |=> fmt_q[3:2] == $past(PKT_BYTE1[3:2])) else $error("Bar field wrong");
   a_scan_field: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      PKT_VALID |=> fmt_q[1:0] == $past(PKT_BYTE1[1:0])) else $error("Scan field wrong");
   a_colr_field: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      PKT_VALID |=> col_q[7:6] == $past(PKT_BYTE2[7:6])) else $error("Colorimetry wrong");
   a_aspect_field: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      PKT_VALID |=> col_q[5:0] == $past(PKT_BYTE2[5:0])) else $error("Aspect fields wrong");
   a_scale_field: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      PKT_VALID |=> scl_q == {6'h00, $past(PKT_BYTE3[1:0])}) else $error("Scaling wrong");
   a_hold_fields: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      !PKT_VALID |=> $stable(fmt_q) && $stable(col_q) && $stable(scl_q))
      else $error("Fields changed without packet");
   a_ack_pulse: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      WB_ACK_O |=> !WB_ACK_O) else $error("Ack held more than one cycle");
   a_ack_timing: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      req |=> WB_ACK_O) else $error("Ack not given one cycle after request");

   c_packet: cover property (@(posedge SYS_CLK) disable iff (!NRST) PKT_VALID);
   c_read_scl: cover property (@(posedge SYS_CLK) disable iff (!NRST)
      req && !WB_WE_I && WB_ADR_I[9:2] == vifs_pkg::VIFS_IDX_SCL);
   c_write: cover property (@(posedge SYS_CLK) disable iff (!NRST) req && WB_WE_I);
   c_pkt_then_read: cover property (@(posedge SYS_CLK) disable iff (!NRST)
      PKT_VALID ##[1:20] (req && !WB_WE_I));
endmodule

/* File: tb/vifs_top_bench.sv */
`timescale 1ns/100ps
// Drives the status block directly and reads it back over Wishbone
module vifs_top_bench;
   logic clk, nrst, pv, cyc, stb, we, ack;
   logic [7:0] b1, b2, b3;
   logic [9:0] adr;
   logic [31:0] dat_o;
   int error_cnt, checks_done;
   // Byte addresses of the three status words
   localparam logic [9:0] A_FMT = {vifs_pkg::VIFS_IDX_FMT, 2'b00};
   localparam logic [9:0] A_COL = {vifs_pkg::VIFS_IDX_COL, 2'b00};
   localparam logic [9:0] A_SCL = {vifs_pkg::VIFS_IDX_SCL, 2'b00};
   vifs_top dut_u (.SYS_CLK(clk), .NRST(nrst), .PKT_BYTE1(b1), .PKT_BYTE2(b2),
      .PKT_BYTE3(b3), .PKT_VALID(pv), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_SEL_I(4'hF), .WB_ADR_I(adr), .WB_DAT_I(32'hFFFFFFFF), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask
   // Classic single cycle; holds the request until ack, bounded wait
   task wb(input logic w, input logic [9:0] a, output logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      d = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (n >= 50) chk("ack", 1'b0, 1'b1);
   endtask
   task pkt(input logic [7:0] x1, input logic [7:0] x2, input logic [7:0] x3);
      @(posedge clk);
      b1 <= x1; b2 <= x2; b3 <= x3; pv <= 1'b1;
      @(posedge clk);
      pv <= 1'b0; b1 <= ~x1; b2 <= ~x2; b3 <= ~x3; // Bytes stale after the pulse
   endtask
   task t_reset;
      logic [31:0] d;
      wb(1'b0, A_FMT, d); chk("fmt rst", d, 32'h0);
      wb(1'b0, A_COL, d); chk("col rst", d, 32'h0);
      wb(1'b0, A_SCL, d); chk("scl rst", d, 32'h0);
      $display("test reset done");
   endtask
   // Every code of every field except active format aspect (codes 8 to 11 only), all three words from one packet
   task t_codes;
      logic [31:0] d;
      logic [1:0] c;
      for (int i = 0; i < 4; i++) begin
         c = i[1:0];
         pkt({1'b1, c, c[0], c, c}, {c, ~c, 2'b10, c}, {6'h3F, c});
         wb(1'b0, A_FMT, d);
         chk("fmt", d, 32'(c) << 5 | 32'(c[0]) << 4 | 32'(c) << 2 | 32'(c));
         wb(1'b0, A_COL, d);
         // Inverse is built at two bits first so the upper bits stay clear
         chk("col", d, {24'h00_0000, c, 2'(~c), 2'b10, c});
         wb(1'b0, A_SCL, d); chk("scl", d, 32'(c));
      end
      $display("test codes done");
   endtask
   // Writes ignored, unmapped read zero, reset mid-run clears
   task t_write;
      logic [31:0] d;
      pkt(8'h55, 8'h9A, 8'h01);
      wb(1'b1, A_FMT, d);
      wb(1'b1, A_SCL, d);
      wb(1'b0, A_FMT, d); chk("fmt ro", d, 32'h55);
      wb(1'b0, A_SCL, d); chk("scl ro", d, 32'h1);
      wb(1'b0, 10'h210, d); chk("unmapped", d, 32'h0);
      @(posedge clk) nrst <= 1'b0;
      @(posedge clk) nrst <= 1'b1;
      wb(1'b0, A_COL, d); chk("col clr", d, 32'h0);
      $display("test write done");
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      nrst = 1'b0; pv = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
      adr = 10'h0; b1 = 8'h0; b2 = 8'h0; b3 = 8'h0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_reset;
      t_codes;
      t_write;
      finish_test;
   end
   // Whole run needs well under 200 cycles
   initial begin
      #10000;
      error_cnt++;
      finish_test;
   end
endmodule
